// ---- rtl/fdms_top.sv ----
// drive select / motor enable register bank with drive decode

// Functional notes
// - control register: motors, enable, reset, select
// - any-time writes; soft reset keeps register
// - select code picks at most one drive
// - reset bit low holds controller reset
// - controller reset lasts at least 100ns
// - legacy modes: enable gates dma/irq pins
// - enable bit reads zero after reset
// - alternate mode: dma/irq pins always enabled
// - motor bits drive motor outputs
// - alt status bits 5,6 show select lines
// - alt status bit 7 shows second drive
// - tape register plain storage, kept on soft reset
// - tape read drives only bits 1:0
// - tape code 00 none, else drive n
// - internal decode: select qualified by motor bit
// - internal swapped: drives 0 and 1 exchanged
// - external decode: code out, motor0 qualified
// - external swapped: codes 00/01 exchanged
module fdms_top (
   // clock and reset
   input  wire logic                  i_clock,
   input  wire logic                  i_rst_b,
   // register port
   input  wire fdms_pkg::fdms_bus_req_t i_bus,
   output logic [7:0]                 o_rdata,
   output logic [7:0]                 o_rdata_oe_n,
   // configuration straps
   input  wire logic                  i_ext_decode,
   input  wire logic                  i_swap_drives,
   input  wire logic                  i_alt_mode,
   // disk interface
   input  wire logic                  i_second_drive_present_n,
   output fdms_pkg::fdms_drive_t      o_drive,
   // controller core side
   output logic                       o_controller_reset,
   output logic [1:0]                 o_tape_pick,
   // dma and interrupt pins
   input  wire logic                  i_dma_req,
   input  wire logic                  i_floppy_irq,
   input  wire logic                  i_dma_ack_n_pin,
   input  wire logic                  i_term_count_pin,
   output logic                       o_dma_req,
   output logic                       o_dma_req_oe_n,
   output logic                       o_floppy_irq,
   output logic                       o_floppy_irq_oe_n,
   output logic                       o_dma_ack_n,
   output logic                       o_term_count
);
   fdms_pkg::fdms_dmc_t dmc_r;
   logic [1:0]          tds_r;
   logic [2:0]          mode_r;
   logic [7:0]          rdata_r;
   logic [7:0]          rdata_oe_n_r;
   logic [1:0]          drv2_sync_r;
   logic [1:0]          ack_sync_r;
   logic [1:0]          tc_sync_r;
   logic [7:0]          rst_cnt_r;
   logic                ctl_rst_r;
   logic                pins_en;
   logic                wr_dmc;
   logic                wr_tds;
   logic                wr_mode;
   logic [1:0]          code;
   fdms_pkg::fdms_drive_t drv_nxt;
   fdms_pkg::fdms_drive_t drv_r;
   logic [7:0]          alt_status;

   function automatic logic [3:0] onehot4(input logic [1:0] c);
      onehot4 = 4'h1 << c;
   endfunction

   assign wr_dmc  = i_bus.wr && (i_bus.addr == fdms_pkg::DMC_OFFSET);
   assign wr_tds  = i_bus.wr && (i_bus.addr == fdms_pkg::TDS_OFFSET);
   assign wr_mode = i_bus.wr && (i_bus.addr == fdms_pkg::MODE_OFFSET);

   // control register; only hardware reset clears it
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         dmc_r <= fdms_pkg::DMC_RESET;
      end else if (wr_dmc) begin
         dmc_r <= i_bus.wdata;
      end
   end

   // tape select, no internal use
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         tds_r <= fdms_pkg::TDS_RESET;
      end else if (wr_tds) begin
         tds_r <= i_bus.wdata[1:0];
      end
   end

   // software copy of configuration straps, or-ed with the pins
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         mode_r <= fdms_pkg::MODE_RESET;
      end else if (wr_mode) begin
         mode_r <= i_bus.wdata[2:0];
      end
   end

   // second-drive, dma ack and terminal count pins pass two flops
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         drv2_sync_r <= 2'h3;
         ack_sync_r  <= 2'h3;
         tc_sync_r   <= 2'h0;
      end else begin
         drv2_sync_r <= {drv2_sync_r[0], i_second_drive_present_n};
         ack_sync_r  <= {ack_sync_r[0], i_dma_ack_n_pin};
         tc_sync_r   <= {tc_sync_r[0], i_term_count_pin};
      end
   end

   // stretch controller reset so a 0-then-1 pair still meets the minimum
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         rst_cnt_r <= 8'(fdms_pkg::RST_MIN_CYC);
      end else if (!dmc_r.controller_reset_n) begin
         rst_cnt_r <= 8'(fdms_pkg::RST_MIN_CYC);
      end else if (rst_cnt_r != 8'h00) begin
         rst_cnt_r <= rst_cnt_r - 8'h01;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         ctl_rst_r <= 1'b1;
      end else begin
         ctl_rst_r <= !dmc_r.controller_reset_n || (rst_cnt_r > 8'h01);
      end
   end
   assign o_controller_reset = ctl_rst_r;

   // drive decode; straps are static, so the pin reads are not synchronised
   always_comb begin
      logic ext;
      logic swp;
      logic [3:0] mot;
      logic [3:0] sel;
      ext = i_ext_decode | mode_r[fdms_pkg::MODE_EXT_BIT];
      swp = i_swap_drives | mode_r[fdms_pkg::MODE_SWAP_BIT];
      mot = dmc_r.motor;
      code = {dmc_r.drive_code_bit1, dmc_r.drive_code_bit0};
      sel = onehot4(code);
      drv_nxt.drive_pick_n  = 4'hf;
      drv_nxt.spindle_out_n = 4'hf;
      if (!ext) begin
         if (!swp) begin
            drv_nxt.drive_pick_n  = ~(sel & mot);
            drv_nxt.spindle_out_n = ~mot;
         end else begin
            drv_nxt.drive_pick_n = ~({sel[3:2], sel[0], sel[1]} &
                                     {mot[3:2], mot[0], mot[1]});
            drv_nxt.spindle_out_n = ~{mot[3:2], mot[0], mot[1]};
         end
      end else begin
         // external decoder: code goes out, motor0 gated by selected drive
         drv_nxt.spindle_out_n[1] = 1'b1;
         drv_nxt.spindle_out_n[0] = ~|(sel & mot);
         if (swp && (code[1] == 1'b0)) begin
            drv_nxt.drive_pick_n[1:0] = {1'b0, ~code[0]};
         end else begin
            drv_nxt.drive_pick_n[1:0] = code;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         drv_r <= '{drive_pick_n: 4'hf, spindle_out_n: 4'hf};
      end else begin
         drv_r <= drv_nxt;
      end
   end
   assign o_drive     = drv_r;
   assign o_tape_pick = tds_r;

   // dma/irq pin gating; alternate mode keeps them on even in reset
   assign pins_en = i_alt_mode | mode_r[fdms_pkg::MODE_ALT_BIT] |
                    dmc_r.dma_irq_enable;
   assign o_dma_req         = i_dma_req;
   assign o_floppy_irq      = i_floppy_irq;
   assign o_dma_req_oe_n    = ~pins_en;
   assign o_floppy_irq_oe_n = ~pins_en;
   assign o_dma_ack_n       = pins_en ? ack_sync_r[1] : 1'b1;
   assign o_term_count      = pins_en ? tc_sync_r[1] : 1'b0;

   // alternate status: reserved bits read as zero here
   always_comb begin
      alt_status = 8'h00;
      alt_status[fdms_pkg::ALT_DS0_BIT]  = drv_r.drive_pick_n[0];
      alt_status[fdms_pkg::ALT_DS1_BIT]  = drv_r.drive_pick_n[1];
      alt_status[fdms_pkg::ALT_DRV2_BIT] = drv2_sync_r[1];
   end

   // read data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         rdata_r      <= 8'h00;
         rdata_oe_n_r <= 8'hff;
      end else if (i_bus.rd) begin
         rdata_oe_n_r <= 8'h00;
         case (i_bus.addr)
            fdms_pkg::DMC_OFFSET:  rdata_r <= dmc_r;
            fdms_pkg::TDS_OFFSET: begin
               rdata_r      <= {6'h00, tds_r};
               rdata_oe_n_r <= 8'hfc;
            end
            fdms_pkg::ALT_OFFSET:  rdata_r <= alt_status;
            fdms_pkg::MODE_OFFSET: rdata_r <= {5'h00, mode_r};
            default:               rdata_r <= 8'h00;
         endcase
      end else begin
         rdata_r      <= 8'h00;
         rdata_oe_n_r <= 8'hff;
      end
   end
   assign o_rdata      = rdata_r;
   assign o_rdata_oe_n = rdata_oe_n_r;
endmodule

// ---- rtl/fdms_pkg.sv ----
// package: register map, field layout and timing constants for drive/motor control
package fdms_pkg;
   localparam logic [9:0] DMC_OFFSET    = 10'h3f2;
   localparam logic [9:0] TDS_OFFSET    = 10'h3f3;
   localparam logic [9:0] ALT_OFFSET    = 10'h3f1;
   localparam logic [9:0] MODE_OFFSET   = 10'h3f8;
   localparam logic [7:0] DMC_RESET     = 8'h00;
   localparam logic [1:0] TDS_RESET     = 2'h0;
   localparam logic [2:0] MODE_RESET    = 3'h0;
   localparam int         MOTOR_LSB     = 4;
   localparam int         DMA_EN_BIT    = 3;
   localparam int         CTRL_RST_BIT  = 2;
   localparam int         ALT_DS0_BIT   = 5;
   localparam int         ALT_DS1_BIT   = 6;
   localparam int         ALT_DRV2_BIT  = 7;
   localparam int         MODE_ALT_BIT  = 0;
   localparam int         MODE_EXT_BIT  = 1;
   localparam int         MODE_SWAP_BIT = 2;
   localparam int         CLK_MHZ       = 125;
   localparam int         RST_MIN_NS    = 100;
   // least time rounds up
   localparam int         RST_MIN_CYC   = (RST_MIN_NS * CLK_MHZ + 999) / 1000;

   typedef struct packed {
      logic [3:0] motor;
      logic       dma_irq_enable;
      logic       controller_reset_n;
      logic       drive_code_bit1;
      logic       drive_code_bit0;
   } fdms_dmc_t;

   typedef struct packed {
      logic [9:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } fdms_bus_req_t;

   typedef struct packed {
      logic [3:0] drive_pick_n;
      logic [3:0] spindle_out_n;
   } fdms_drive_t;
endpackage

// ---- sim/fdms_monitor.sv ----
// checker on the drive/motor control bank ports
module fdms_monitor (
   // watched ports
   input wire logic                    i_clock,
   input wire logic                    i_rst_b,
   input wire fdms_pkg::fdms_bus_req_t i_bus,
   input wire logic [7:0]              o_rdata,
   input wire logic [7:0]              o_rdata_oe_n,
   input wire logic                    i_ext_decode,
   input wire logic                    i_alt_mode,
   input wire fdms_pkg::fdms_drive_t   o_drive,
   input wire logic                    o_controller_reset,
   input wire logic                    o_dma_req_oe_n,
   input wire logic                    o_floppy_irq_oe_n
);
   logic dmc_wr;
   assign dmc_wr = i_bus.wr && i_bus.addr == 10'h3f2;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   AST_HW_RST: assert property (disable iff (1'b0)
      !i_rst_b[*3] |-> o_drive == 8'hff) else $error("drive lines not idle");
   // strap change needs one edge to reach the pins
   AST_ONE_PICK: assert property (!i_ext_decode[*3] |->
      $onehot0(~o_drive.drive_pick_n)) else $error("several drives picked");
   AST_SW_RST: assert property (dmc_wr && !i_bus.wdata[2] |->
      ##2 o_controller_reset) else $error("soft reset not raised");
   AST_RST_MIN: assert property ($rose(o_controller_reset) |->
      o_controller_reset[*8] ##1 o_controller_reset[*5])
      else $error("soft reset too short");
   AST_DMA_EN: assert property (dmc_wr && !i_alt_mode |=>
      o_dma_req_oe_n == !$past(i_bus.wdata[3])) else $error("dma gate");
   AST_DMA_RST: assert property (disable iff (1'b0)
      !i_rst_b && !i_alt_mode |=> o_dma_req_oe_n && o_floppy_irq_oe_n)
      else $error("dma pins driven after reset");
   AST_ALT_ON: assert property (disable iff (1'b0)
      i_alt_mode |-> !o_dma_req_oe_n && !o_floppy_irq_oe_n)
      else $error("dma pins off in alternate mode");
   AST_TAPE_OE: assert property (i_bus.rd &&
      i_bus.addr == 10'h3f3 |=> o_rdata_oe_n == 8'hfc &&
      o_rdata[7:2] == 6'h0) else $error("tape read drives high bits");
endmodule

bind fdms_top fdms_monitor i_fdms_monitor (.i_clock, .i_rst_b, .i_bus,
   .o_rdata, .o_rdata_oe_n, .i_ext_decode, .i_alt_mode, .o_drive,
   .o_controller_reset, .o_dma_req_oe_n, .o_floppy_irq_oe_n);

// ---- sim/fdms_drive_model.sv ----
// drive cable side: reports whether a second drive is fitted
module fdms_drive_model (
   // strap
   input  wire logic i_installed,
   // cable pin, pulled high when no drive is fitted
   output logic      o_second_drive_present_n
);
   timeunit 1ns;
   timeprecision 1ps;
   assign o_second_drive_present_n = !i_installed;
endmodule

// ---- sim/fdms_tb_top.sv ----
// self-checking bench for the drive/motor control bank
module fdms_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                    i_clock = 1'b0;
   logic                    i_rst_b = 1'b0;
   fdms_pkg::fdms_bus_req_t bus = '0;
   fdms_pkg::fdms_drive_t   drv;
   logic [7:0]              rdata, oe_n;
   logic [5:0]              pins;
   logic [1:0]              tape;
   logic                    ext = 1'b0, swp = 1'b0, alt = 1'b0, inst = 1'b0;
   logic                    dreq = 1'b0, irq = 1'b0, ack_n = 1'b1, tc = 1'b0;
   logic                    crst, drv2_n, dro, dro_n, iro, iro_n, acko, tco;
   int                      fail_count = 0, n_tests = 0, cyc = 0;
   assign pins = {dro_n, iro_n, dro, iro, acko, tco};
   always #4 i_clock = ~i_clock;
   fdms_top i_fdms_top (.i_clock, .i_rst_b, .i_bus(bus), .o_rdata(rdata),
      .o_rdata_oe_n(oe_n), .i_ext_decode(ext), .i_swap_drives(swp),
      .i_alt_mode(alt), .i_second_drive_present_n(drv2_n), .o_drive(drv),
      .o_controller_reset(crst), .o_tape_pick(tape), .i_dma_req(dreq),
      .i_floppy_irq(irq), .i_dma_ack_n_pin(ack_n), .i_term_count_pin(tc),
      .o_dma_req(dro), .o_dma_req_oe_n(dro_n), .o_floppy_irq(iro),
      .o_floppy_irq_oe_n(iro_n), .o_dma_ack_n(acko), .o_term_count(tco));
   fdms_drive_model i_fdms_drive_model (.i_installed(inst),
      .o_second_drive_present_n(drv2_n));
   task chk(input string nm, input logic [7:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task tally_and_finish;
      if (fail_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task step;
      @(posedge i_clock);
      #1;
   endtask
   // one strobe cycle; returns inside the answer cycle
   task op(input logic [9:0] a, input logic [7:0] d, input logic w);
      @(posedge i_clock);
      bus <= '{a, d, w, !w};
      step;
      bus <= '0;
   endtask
   task rd(input logic [9:0] a, input logic [7:0] e, eoe, input string nm);
      op(a, 8'h00, 1'b0);
      chk(nm, rdata, e);
      chk(nm, oe_n, eoe);
   endtask
   task t_reset;
      rd(10'h3f2, 8'h00, 8'h00, "dmc");
      chk("drv", drv, 8'hff);
      chk("oe", pins[5:4], 8'h03);
      rd(10'h3f1, 8'he0, 8'h00, "alt");
   endtask
   task t_decode;
      logic [3:0] m, p;
      logic [1:0] c;
      logic [7:0] w, e;
      for (int md = 0; md < 4; md++)
         for (int i = 0; i < 8; i++) begin
            @(posedge i_clock);
            {ext, swp} <= md[1:0];
            c = i[1:0];
            m = (i < 4) ? 4'h1 << c : 4'h0;
            w = {m, 4'hc} | {6'h0, c};
            p = md[0] ? {m[3:2], m[0], m[1]} : m;
            e = {2'b00, c ^ {1'b0, md[0] & ~c[1]}, 3'b111, ~|m};
            if (!md[1]) e = {~p, ~p};
            op(10'h3f2, w, 1'b1);
            step;
            chk("drv", drv & (md[1] ? 8'h3f : 8'hff), e);
            rd(10'h3f1, {1'b0, e[5:4], 5'h0}, 8'h00, "alt");
            rd(10'h3f2, w, 8'h00, "dmc");
         end
   endtask
   task t_swrst;
      @(posedge i_clock);
      {ext, swp} <= 2'b00;
      op(10'h3f3, 8'hfe, 1'b1);
      op(10'h3f2, 8'h18, 1'b1);
      step;
      chk("crst", crst, 8'h01);
      chk("drv", drv, 8'hee);
      rd(10'h3f2, 8'h18, 8'h00, "dmc");
      rd(10'h3f3, 8'h02, 8'hfc, "tds");
      op(10'h3f2, 8'h1c, 1'b1);
      chk("drv", drv, 8'hee);
      repeat (2) step;
      chk("crst", crst, 8'h01);
      repeat (20) step;
      chk("crst", crst, 8'h00);
   endtask
   task t_tape;
      for (int k = 0; k < 4; k++) begin
         op(10'h3f3, 8'hfc | 8'(k), 1'b1);
         rd(10'h3f3, 8'(k), 8'hfc, "tds");
         chk("pick", tape, 8'(k));
      end
      op(10'h3f6, 8'hff, 1'b1);
      op(10'h3f6, 8'h00, 1'b0);
      chk("unmapped", rdata, 8'h00);
      rd(10'h3f2, 8'h1c, 8'h00, "dmc");
   endtask
   task t_dma;
      @(posedge i_clock);
      {dreq, irq, ack_n, tc} <= 4'b1101;
      op(10'h3f2, 8'h0c, 1'b1);
      repeat (3) step;
      chk("pins", pins, 8'h0d);
      op(10'h3f2, 8'h04, 1'b1);
      repeat (3) step;
      chk("pins", pins, 8'h3e);
      @(posedge i_clock);
      alt <= 1'b1;
      repeat (3) step;
      chk("pins", pins, 8'h0d);
      @(posedge i_clock);
      i_rst_b <= 1'b0;
      repeat (3) step;
      chk("oe", pins[5:4], 8'h00);
      @(posedge i_clock);
      i_rst_b <= 1'b1;
      rd(10'h3f2, 8'h00, 8'h00, "dmc");
   endtask
   // whole run is a few hundred cycles
   always @(posedge i_clock) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         tally_and_finish;
      end
   end
   initial begin
      repeat (5) @(posedge i_clock);
      i_rst_b <= 1'b1;
      t_reset;
      @(posedge i_clock);
      inst <= 1'b1;
      t_decode;
      t_swrst;
      t_tape;
      t_dma;
      tally_and_finish;
   end
endmodule
